// File: rtl/frr_top.sv
// fault restart supervisor and dc bus dip-ride controller
// bus comparators, fault flags and commands are synchronous to clk;
// frequency ramping itself is done outside, steered by the ramp outputs
`include "frr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module frr_top #(
  parameter int unsigned HOLD_CYCLES = `FRR_HOLD_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] after_fault_treatment,
  input  wire logic [3:0] restart_attempt_count,
  input  wire logic [1:0] startup_search_select,
  input  wire logic [1:0] dip_ride_select,
  input  wire logic [4:0] mo_function_code,
  input  wire logic       output_block_input,
  input  wire logic       output_block_event,
  input  wire logic       overcurrent_fault,
  input  wire logic       overvoltage_fault,
  input  wire logic       short_circuit_fault,
  input  wire logic       relay_fault,
  input  wire logic       external_fault_input,
  input  wire logic       manual_reset,
  input  wire logic       run_cmd,
  input  wire logic       stop_cmd,
  input  wire logic       bus_below_dip_level,
  input  wire logic       bus_above_dip_return,
  input  wire logic       bus_below_low_level,
  input  wire logic       bus_above_low_return,
  input  wire logic       bus_stable,
  input  wire logic       current_above_search_limit,
  input  wire logic       freq_at_zero,
  output logic            fault_latched,
  output logic [4:0]      recorded_faults,
  output logic            auto_reset_pulse,
  output logic            search_active,
  output logic [1:0]      search_source,
  output logic            output_enable,
  output logic            soft_start_relay,
  output logic            ramp_down,
  output logic            ramp_hold,
  output logic            ramp_up,
  output logic            dip_warning,
  output logic            low_volt_warning,
  output logic            multi_function_output,
  output logic [3:0]      attempts_used
);
  frr_pkg::frr_dip_e dip_reg;
  frr_pkg::frr_dip_e dip_next;
  logic              hold_start;
  logic              hold_busy;
  logic              hold_done;
  logic              dip_active;
  logic              restartable;
  logic              hard_fault;
  logic              qual_fault;
  logic              block_evt;
  logic              limit_ok;
  logic              restart_ok_reg;
  logic              search_req_reg;
  logic [1:0]        search_src_reg;

  function automatic logic [1:0] aft_src(input logic [1:0] sel);
    unique case (sel)
      `FRR_AFT_PRESENT: aft_src = frr_pkg::FRR_SRC_PRESENT;
      `FRR_AFT_MINIMUM: aft_src = frr_pkg::FRR_SRC_MIN;
      default:          aft_src = frr_pkg::FRR_SRC_NONE;
    endcase
  endfunction

  function automatic logic [1:0] sus_src(input logic [1:0] sel);
    unique case (sel)
      `FRR_SUS_MAX:   sus_src = frr_pkg::FRR_SRC_MAX;
      `FRR_SUS_MOTOR: sus_src = frr_pkg::FRR_SRC_PRESENT;
      `FRR_SUS_MIN:   sus_src = frr_pkg::FRR_SRC_MIN;
      default:        sus_src = frr_pkg::FRR_SRC_NONE;
    endcase
  endfunction

  assign dip_active = (dip_reg != frr_pkg::FRR_DIP_IDLE);
  // block input ignored while dip-ride runs
  assign block_evt  = (output_block_event | output_block_input)
                    & ~dip_active;
  assign hard_fault = overcurrent_fault | overvoltage_fault
                    | short_circuit_fault;
  assign qual_fault = block_evt | hard_fault;
  // settings above 10 are clamped so an illegal value never loops forever
  assign limit_ok   = (restart_attempt_count > `FRR_ATTEMPT_MAX) ?
                      (attempts_used < `FRR_ATTEMPT_MAX) :
                      (attempts_used < restart_attempt_count);
  assign restartable = (restart_attempt_count != 4'h0) & limit_ok
                     & (after_fault_treatment != `FRR_AFT_STOP);

  // fault latch and automatic restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_latched    <= 1'b0;
      auto_reset_pulse <= 1'b0;
      attempts_used    <= 4'h0;
      restart_ok_reg   <= 1'b0;
    end else begin
      auto_reset_pulse <= 1'b0;
      if (manual_reset & ~(dip_reg == frr_pkg::FRR_DIP_DECEL)) begin
        fault_latched  <= 1'b0;
        restart_ok_reg <= 1'b0;
        attempts_used  <= 4'h0;
      end else if (relay_fault | external_fault_input) begin
        fault_latched  <= 1'b1;
        restart_ok_reg <= 1'b0;
      end else if (qual_fault & ~fault_latched) begin
        fault_latched  <= 1'b1;
        // eligibility is sampled when the fault lands, and current settings must still allow the restart
        restart_ok_reg <= restartable;
      end else if (fault_latched & restart_ok_reg & restartable
                   & ~qual_fault) begin
        fault_latched    <= 1'b0;
        restart_ok_reg   <= 1'b0;
        auto_reset_pulse <= 1'b1;
        attempts_used    <= attempts_used + 4'h1;
      end
    end
  end

  // fault record stays live during dip-ride
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recorded_faults <= 5'h00;
    end else if (manual_reset & (dip_reg != frr_pkg::FRR_DIP_DECEL)) begin
      // a fault in the clearing cycle is still kept
      recorded_faults <= {external_fault_input, relay_fault,
        short_circuit_fault, overvoltage_fault, overcurrent_fault};
    end else begin
      recorded_faults <= recorded_faults | {external_fault_input,
        relay_fault, short_circuit_fault, overvoltage_fault,
        overcurrent_fault};
    end
  end

  // speed search request: after auto reset, or at start-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      search_req_reg <= 1'b0;
      search_src_reg <= frr_pkg::FRR_SRC_NONE;
    end else if (auto_reset_pulse) begin
      search_req_reg <= (aft_src(after_fault_treatment)
                        != frr_pkg::FRR_SRC_NONE);
      search_src_reg <= aft_src(after_fault_treatment);
    end else if (run_cmd & ~output_enable & ~fault_latched) begin
      search_req_reg <= (startup_search_select != `FRR_SUS_OFF);
      search_src_reg <= sus_src(startup_search_select);
    end else if (search_active | fault_latched) begin
      search_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      search_active <= 1'b0;
      search_source <= frr_pkg::FRR_SRC_NONE;
    end else begin
      search_active <= search_req_reg & current_above_search_limit;
      search_source <= search_src_reg;
    end
  end

  // run state; stop ignored during dip-ride deceleration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_enable <= 1'b0;
    end else if (fault_latched | qual_fault | relay_fault
                 | external_fault_input) begin
      output_enable <= 1'b0;
    end else if (stop_cmd & (dip_reg != frr_pkg::FRR_DIP_DECEL)) begin
      output_enable <= 1'b0;
    end else if (dip_reg == frr_pkg::FRR_DIP_STOP
                 || dip_reg == frr_pkg::FRR_DIP_DEAD) begin
      output_enable <= ~freq_at_zero & output_enable;
    end else if (run_cmd | auto_reset_pulse) begin
      output_enable <= 1'b1;
    end
  end

  // dip-ride state machine
  always_comb begin
    dip_next   = dip_reg;
    hold_start = 1'b0;
    unique case (dip_reg)
      frr_pkg::FRR_DIP_IDLE: begin
        if (bus_below_dip_level & output_enable
            & (dip_ride_select != `FRR_DIP_OFF)) begin
          dip_next = frr_pkg::FRR_DIP_DECEL;
        end
      end
      frr_pkg::FRR_DIP_DECEL: begin
        if (bus_below_low_level) begin
          dip_next = frr_pkg::FRR_DIP_DEAD;
        end else if (bus_above_dip_return & bus_stable) begin
          if (dip_ride_select == `FRR_DIP_RETURN) begin
            dip_next   = frr_pkg::FRR_DIP_HOLD;
            hold_start = 1'b1;
          end else begin
            dip_next = frr_pkg::FRR_DIP_STOP;
          end
        end
      end
      frr_pkg::FRR_DIP_HOLD: begin
        if (bus_below_dip_level) begin
          dip_next = frr_pkg::FRR_DIP_DECEL;
        end else if (hold_done) begin
          dip_next = frr_pkg::FRR_DIP_ACCEL;
        end
      end
      frr_pkg::FRR_DIP_ACCEL: begin
        dip_next = frr_pkg::FRR_DIP_IDLE;
      end
      frr_pkg::FRR_DIP_STOP: begin
        if (manual_reset) begin
          dip_next = frr_pkg::FRR_DIP_IDLE;
        end
      end
      frr_pkg::FRR_DIP_DEAD: begin
        if (dip_ride_select == `FRR_DIP_RETURN & soft_start_relay
            & bus_above_dip_return & bus_stable) begin
          dip_next   = frr_pkg::FRR_DIP_HOLD;
          hold_start = 1'b1;
        end else if (manual_reset & ~bus_below_low_level) begin
          dip_next = frr_pkg::FRR_DIP_IDLE;
        end
      end
      default: dip_next = frr_pkg::FRR_DIP_IDLE;
    endcase
    if (dip_ride_select == `FRR_DIP_OFF) begin
      dip_next = frr_pkg::FRR_DIP_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dip_reg <= frr_pkg::FRR_DIP_IDLE;
    end else begin
      dip_reg <= dip_next;
    end
  end

  frr_hold_timer #(
    .CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clk   (clk),
    .rst   (rst),
    .start (hold_start),
    .abort (dip_reg != frr_pkg::FRR_DIP_HOLD && !hold_start),
    .busy  (hold_busy),
    .done  (hold_done)
  );

  // relay: open below low level once dead, reclose above low return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_start_relay <= 1'b1;
    end else if (dip_next == frr_pkg::FRR_DIP_DEAD) begin
      if (bus_below_low_level) begin
        soft_start_relay <= 1'b0;
      end else if (bus_above_low_return) begin
        soft_start_relay <= 1'b1;
      end
    end else begin
      soft_start_relay <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_down   <= 1'b0;
      ramp_hold   <= 1'b0;
      ramp_up     <= 1'b0;
      dip_warning <= 1'b0;
    end else begin
      ramp_down <= (dip_next == frr_pkg::FRR_DIP_DECEL)
                 | (dip_next == frr_pkg::FRR_DIP_STOP)
                 | (dip_next == frr_pkg::FRR_DIP_DEAD);
      ramp_hold <= (dip_next == frr_pkg::FRR_DIP_HOLD);
      ramp_up   <= (dip_next == frr_pkg::FRR_DIP_ACCEL);
      // warning clears by itself only on the return path
      dip_warning <= (dip_next != frr_pkg::FRR_DIP_IDLE)
                   & (dip_next != frr_pkg::FRR_DIP_ACCEL);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_volt_warning      <= 1'b0;
      multi_function_output <= 1'b0;
    end else begin
      low_volt_warning <= bus_below_low_level
                        & (dip_next == frr_pkg::FRR_DIP_IDLE);
      multi_function_output <= bus_below_low_level
        & (mo_function_code == `FRR_MO_LOW_VOLT);
    end
  end

  sequence s_dip_entry;
    dip_reg == frr_pkg::FRR_DIP_IDLE && bus_below_dip_level
      && output_enable && dip_ride_select != `FRR_DIP_OFF;
  endsequence

  AST_DIP_START: assert property (@(posedge clk) disable iff (rst)
    s_dip_entry |=> dip_reg == frr_pkg::FRR_DIP_DECEL && ramp_down)
    else $error("dip-ride did not start deceleration");
  AST_ZERO_NO_RESTART: assert property (@(posedge clk) disable iff (rst)
    restart_attempt_count == 4'h0 |-> !auto_reset_pulse)
    else $error("auto restart with zero count");
  AST_LIMIT: assert property (@(posedge clk) disable iff (rst)
    auto_reset_pulse |-> attempts_used <= restart_attempt_count)
    else $error("restart count exceeded");
  AST_STOP_IGNORED: assert property (@(posedge clk) disable iff (rst)
    dip_reg == frr_pkg::FRR_DIP_DECEL && output_enable && stop_cmd
    && !fault_latched && !qual_fault && !relay_fault
    && !external_fault_input |=> output_enable)
    else $error("stop honoured during dip-ride");
  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (rst)
    manual_reset && dip_reg != frr_pkg::FRR_DIP_DECEL
    |=> attempts_used == 4'h0)
    else $error("manual reset left attempts");
  AST_MO_LOW: assert property (@(posedge clk) disable iff (rst)
    bus_below_low_level && mo_function_code == `FRR_MO_LOW_VOLT
    |=> multi_function_output)
    else $error("low voltage output missing");
  AST_NO_LV_WARN: assert property (@(posedge clk) disable iff (rst)
    dip_active && dip_next != frr_pkg::FRR_DIP_IDLE
    |=> !low_volt_warning)
    else $error("low voltage warning shown in dip-ride");
  AST_SEARCH_CUR: assert property (@(posedge clk) disable iff (rst)
    search_active |-> $past(current_above_search_limit))
    else $error("search without current");
  AST_RELAY_OPEN: assert property (@(posedge clk) disable iff (rst)
    dip_reg == frr_pkg::FRR_DIP_DECEL && bus_below_low_level
    && dip_ride_select != `FRR_DIP_OFF |=> !soft_start_relay)
    else $error("relay stayed closed below low level");
  AST_SRC_AFTER: assert property (@(posedge clk) disable iff (rst)
    auto_reset_pulse |=> search_src_reg == aft_src($past(
    after_fault_treatment)))
    else $error("wrong search source after reset");
  AST_HOLD_TIMED: assert property (@(posedge clk) disable iff (rst)
    dip_reg == frr_pkg::FRR_DIP_HOLD |-> hold_busy)
    else $error("frequency hold without running timer");
endmodule
`default_nettype wire

// File: rtl/frr_map.svh
// fault restart and dc dip ride constants, selector codes and timing
// assumes a 50 MHz system clock; included by bare name
`ifndef FRR_MAP_SVH
`define FRR_MAP_SVH
`define FRR_AFT_STOP        2'h0
`define FRR_AFT_PRESENT     2'h1
`define FRR_AFT_MINIMUM     2'h2
`define FRR_SUS_OFF         2'h0
`define FRR_SUS_MAX         2'h1
`define FRR_SUS_MOTOR       2'h2
`define FRR_SUS_MIN         2'h3
`define FRR_DIP_OFF         2'h0
`define FRR_DIP_NORETURN    2'h1
`define FRR_DIP_RETURN      2'h2
`define FRR_ATTEMPT_MAX     4'hA
`define FRR_HOLD_MS         3000
`define FRR_CLK_HZ          50000000
`define FRR_HOLD_CYCLES     ((`FRR_HOLD_MS * (`FRR_CLK_HZ / 1000)))
`define FRR_MO_LOW_VOLT     5'h0A
`endif

// File: rtl/frr_pkg.sv
// types shared by the fault restart and dip-ride logic
// no assumptions beyond a single clock domain
package frr_pkg;
  typedef enum logic [2:0] {
    FRR_DIP_IDLE  = 3'b000,
    FRR_DIP_DECEL = 3'b001,
    FRR_DIP_HOLD  = 3'b011,
    FRR_DIP_ACCEL = 3'b010,
    FRR_DIP_STOP  = 3'b110,
    FRR_DIP_DEAD  = 3'b111
  } frr_dip_e;
  typedef enum logic [1:0] {
    FRR_SRC_NONE    = 2'b00,
    FRR_SRC_MAX     = 2'b01,
    FRR_SRC_PRESENT = 2'b11,
    FRR_SRC_MIN     = 2'b10
  } frr_src_e;
endpackage

// File: rtl/frr_hold_timer.sv
// dwell counter for the post-recovery frequency hold
// start is a one-cycle pulse; done pulses once the count has elapsed
`timescale 1ns/1ps
`default_nettype none
module frr_hold_timer #(
  parameter int unsigned CYCLES = 150000000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt_reg;

  // combinational so the caller leaves its hold after exactly CYCLES clocks
  assign done = busy & (cnt_reg == CYCLES[31:0] - 32'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      busy    <= 1'b0;
    end else begin
      if (abort) begin
        busy    <= 1'b0;
        cnt_reg <= 32'h0;
      end else if (start) begin
        busy    <= 1'b1;
        cnt_reg <= 32'h0;
      end else if (busy) begin
        if (done) begin
          busy <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/frr_bus_model.sv
// behavioural dc bus monitor and motor frequency seen by the supervisor
// assumes supply_on changes off the rising edge; levels move one step a cycle
`timescale 1ns/1ps
`default_nettype none
module frr_bus_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic supply_on,
  input  wire logic ramp_down,
  input  wire logic ramp_up,
  output logic      below_dip,
  output logic      above_dip_ret,
  output logic      below_low,
  output logic      above_low_ret,
  output logic      stable,
  output logic      at_zero
);
  // slow sag so every comparator threshold is crossed in its own order
  logic [6:0] volt_reg;
  logic [7:0] freq_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      volt_reg <= 7'h64;
    end else if (supply_on && volt_reg < 7'h64) begin
      volt_reg <= volt_reg + 7'h01;
    end else if (!supply_on && volt_reg != 7'h00) begin
      volt_reg <= volt_reg - 7'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_reg <= 8'hC8;
    end else if (ramp_down && freq_reg != 8'h00) begin
      freq_reg <= freq_reg - 8'h01;
    end else if (ramp_up && freq_reg != 8'hC8) begin
      freq_reg <= freq_reg + 8'h01;
    end
  end
  assign below_dip     = volt_reg < 7'h46;
  assign above_dip_ret = volt_reg > 7'h50;
  assign below_low     = volt_reg < 7'h32;
  assign above_low_ret = volt_reg > 7'h3C;
  // only a fully recharged bus counts as settled
  assign stable        = volt_reg == 7'h64;
  assign at_zero       = freq_reg == 8'h00;
endmodule
`default_nettype wire

// File: verification/test_frr_top.sv
// self-checking bench for the fault restart and dip-ride supervisor
// inputs change on the falling edge; hold time shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_frr_top;
  localparam int unsigned HOLD = 20;
  logic       clk = 1'b0;
  logic       rst, oblk_in, oblk_ev, oc, ov, sc, rly, ef;
  logic       mrst, run, stop, cur, supply;
  logic [1:0] aft, sus, dip, ssrc;
  logic [3:0] cnt, used;
  logic [4:0] mo, rec;
  logic       b_dip, b_dret, b_low, b_lret, b_stab, f_zero;
  logic       flt, arp, s_act, oe, relay, rdn, rhold, rup, dwarn, lvw, mfo;
  int         n_mismatch, compares, n_pulse, i, k;
  frr_pkg::frr_src_e exp_src [4] = '{frr_pkg::FRR_SRC_NONE,
    frr_pkg::FRR_SRC_MAX, frr_pkg::FRR_SRC_PRESENT, frr_pkg::FRR_SRC_MIN};

  frr_top #(.HOLD_CYCLES(HOLD)) uut (
    .clk(clk), .rst(rst), .after_fault_treatment(aft),
    .restart_attempt_count(cnt), .startup_search_select(sus),
    .dip_ride_select(dip), .mo_function_code(mo),
    .output_block_input(oblk_in), .output_block_event(oblk_ev),
    .overcurrent_fault(oc), .overvoltage_fault(ov),
    .short_circuit_fault(sc), .relay_fault(rly),
    .external_fault_input(ef), .manual_reset(mrst), .run_cmd(run),
    .stop_cmd(stop), .bus_below_dip_level(b_dip),
    .bus_above_dip_return(b_dret), .bus_below_low_level(b_low),
    .bus_above_low_return(b_lret), .bus_stable(b_stab),
    .current_above_search_limit(cur), .freq_at_zero(f_zero),
    .fault_latched(flt), .recorded_faults(rec), .auto_reset_pulse(arp),
    .search_active(s_act), .search_source(ssrc), .output_enable(oe),
    .soft_start_relay(relay), .ramp_down(rdn), .ramp_hold(rhold),
    .ramp_up(rup), .dip_warning(dwarn), .low_volt_warning(lvw),
    .multi_function_output(mfo), .attempts_used(used)
  );
  frr_bus_model bus (
    .clk(clk), .rst(rst), .supply_on(supply), .ramp_down(rdn),
    .ramp_up(rup), .below_dip(b_dip), .above_dip_ret(b_dret),
    .below_low(b_low), .above_low_ret(b_lret), .stable(b_stab),
    .at_zero(f_zero)
  );

  always #10 clk = ~clk;
  // the restart pulse lasts one cycle, so it is counted rather than sampled
  always @(posedge clk) begin
    if (arp === 1'b1) n_pulse++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start(input logic [1:0] d);
    rst = 1'b1;
    {oblk_in, oblk_ev, oc, ov, sc, rly, ef, mrst, run, stop, cur} = 11'h000;
    {aft, sus, cnt, mo} = 13'h0000;
    dip = d;
    supply = 1'b1;
    n_pulse = 0;
    cyc(3);
    rst = 1'b0;
    cyc(1);
  endtask
  task automatic pulse_fault(input logic [4:0] which);
    {ef, rly, sc, ov, oc} = which;
    cyc(1);
    {ef, rly, sc, ov, oc} = 5'h00;
    cyc(5);
  endtask
  task automatic dip_enter(input logic [1:0] d);
    start(d);
    mo = 5'h0A;
    run = 1'b1;
    for (i = 0; i < 10 && oe !== 1'b1; i++) cyc(1);
    supply = 1'b0;
    for (i = 0; i < 60 && rdn !== 1'b1; i++) cyc(1);
  endtask
  task automatic hold_then_rise();
    for (i = 0; i < 100 && rhold !== 1'b1; i++) cyc(1);
    for (k = 0; k < 100 && rhold === 1'b1; k++) cyc(1);
    chk(k[7:0], HOLD[7:0]);
    chk(rup, 1'b1);
    cyc(3);
    chk(dwarn, 1'b0);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    start(2'h0);
    aft = 2'h1;
    run = 1'b1;
    pulse_fault(5'h02);
    chk(flt, 1'b1);
    chk(n_pulse[7:0], 8'h00);
    start(2'h0);
    cnt = 4'h3;
    run = 1'b1;
    pulse_fault(5'h01);
    chk(n_pulse[7:0], 8'h00);
    aft = 2'h1;
    pulse_fault(5'h18);
    chk(flt, 1'b1);
    chk(n_pulse[7:0], 8'h00);
    chk(rec, 5'h19);
    for (k = 1; k < 3; k++) begin
      start(2'h0);
      aft = k[1:0];
      cnt = 4'h2;
      run = 1'b1;
      pulse_fault(5'h04);
      chk(n_pulse[7:0], 8'h01);
      chk(used, 4'h1);
      chk(s_act, 1'b0);
      cur = 1'b1;
      for (i = 0; i < 10 && s_act !== 1'b1; i++) cyc(1);
      chk(ssrc, exp_src[k == 1 ? 2 : 3]);
    end
    pulse_fault(5'h01);
    chk(used, 4'h2);
    pulse_fault(5'h02);
    chk(n_pulse[7:0], 8'h02);
    chk(flt, 1'b1);
    mrst = 1'b1;
    cyc(1);
    mrst = 1'b0;
    cyc(2);
    chk({flt, used}, 5'h00);
    rst = 1'b1;
    cyc(1);
    chk({relay, flt, oe, rdn, dwarn, 3'h0}, 8'h80);
    chk({3'h0, rec}, 8'h00);
    chk({4'h0, used}, 8'h00);
    for (k = 0; k < 4; k++) begin
      start(2'h0);
      sus = k[1:0];
      cur = 1'b1;
      cyc(1);
      run = 1'b1;
      for (i = 0; i < 10 && s_act !== 1'b1; i++) cyc(1);
      chk(s_act, k != 0);
      chk(ssrc, exp_src[k]);
    end
    dip_enter(2'h0);
    chk({rdn, dwarn}, 2'h0);
    dip_enter(2'h2);
    chk({rdn, dwarn, relay}, 3'h7);
    {stop, mrst, oblk_ev, oblk_in} = 4'hF;
    cyc(1);
    {stop, mrst} = 2'h0;
    cyc(2);
    {oblk_ev, oblk_in} = 2'h0;
    chk({rdn, oe}, 2'h3);
    chk(flt, 1'b0);
    supply = 1'b1;
    hold_then_rise();
    dip_enter(2'h2);
    for (i = 0; i < 60 && b_low !== 1'b1; i++) cyc(1);
    cyc(2);
    chk({mfo, lvw}, 2'h2);
    for (i = 0; i < 400 && f_zero !== 1'b1; i++) cyc(1);
    chk({relay, f_zero, dwarn}, 3'h3);
    supply = 1'b1;
    for (i = 0; i < 100 && relay !== 1'b1; i++) cyc(1);
    chk({relay, b_lret}, 2'h3);
    hold_then_rise();
    dip_enter(2'h1);
    supply = 1'b1;
    for (i = 0; i < 400 && f_zero !== 1'b1; i++) cyc(1);
    cyc(40);
    chk({rup, rhold, dwarn}, 3'h1);
    mrst = 1'b1;
    cyc(1);
    mrst = 1'b0;
    cyc(3);
    chk(dwarn, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
